//--- rtl/lss_pkg.sv
package lss_pkg;
	// ------------------------------------------------------------
	// frame layout
	// ------------------------------------------------------------
	localparam int FRAME_BITS = 16;
	localparam int ADDR_MSB = 14;
	localparam int ADDR_LSB = 10;
	localparam int ADDR_BITS = 5;
	localparam int DATA_BITS = 10;
	localparam int NUM_REGS = 32;
	localparam int NUM_OUT = 4;
	// ------------------------------------------------------------
	// register addresses and field positions
	// ------------------------------------------------------------
	localparam logic [4:0] ADDR_OUT_CTRL = 5'h01;
	localparam logic [4:0] ADDR_SENSE = 5'h02;
	localparam logic [4:0] ADDR_DUTY0 = 5'h04;
	localparam logic [4:0] ADDR_DUTY_CFG = 5'h08;
	localparam logic [4:0] ADDR_FAULT_CLR = 5'h0F;
	localparam int SNS_SEL_LSB = 0;
	localparam int SNS_TEMP_BIT = 2;
	localparam int SNS_HIZ_BIT = 3;
	localparam int DCFG_EN_BIT = 0;
	localparam int DCFG_SRC_BIT = 1;
	localparam logic [9:0] REG_RESET = 10'h000;
	localparam logic [7:0] DUTY_FULL = 8'hFF;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int SYS_CLK_MHZ = 250;
	localparam int WDOG_TIME_US = 1000;
	localparam int WDOG_CYCLES = WDOG_TIME_US * SYS_CLK_MHZ;
	localparam int CLKFAIL_TIME_US = 1000;
	localparam int CLKFAIL_CYCLES = CLKFAIL_TIME_US * SYS_CLK_MHZ;
	// sense mux selections
	typedef enum logic [1:0] {
		LSS_SNS_HIZ = 2'h0,
		LSS_SNS_CUR = 2'h1,
		LSS_SNS_TEMP = 2'h2
	} lss_sns_t;
	// top-level mode, one-hot
	typedef enum logic [2:0] {
		LSS_SLEEP = 3'h1,
		LSS_NORMAL = 3'h2,
		LSS_FAULT = 3'h4
	} lss_mode_t;
endpackage

//--- rtl/lss_regmem.sv
`timescale 1ns/1ps
// small register memory, registered read port
module lss_regmem #(
	parameter int AW = 5,
	parameter int DW = 10
) (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// write port
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [DW-1:0] wr_data,
	// read port
	input wire logic [AW-1:0] rd_addr,
	output logic [DW-1:0] rd_data
);
	logic [DW-1:0] mem_r [2**AW];
	// write with synchronous clear so reset returns all to zero
	always_ff @(posedge clk) begin
		for (int i = 0; i < 2**AW; i++) begin
			if (!nrst) begin
				mem_r[i] <= '0;
			end else if (wr_en && wr_addr == AW'(i)) begin
				mem_r[i] <= wr_data;
			end
		end
	end
	always_ff @(posedge clk) begin
		if (!nrst) begin
			rd_data <= '0;
		end else begin
			rd_data <= mem_r[rd_addr];
		end
	end
endmodule

//--- rtl/lss_serial_port.sv
`timescale 1ns/1ps
// Functional notes
// - one sixteen bit word each way per frame
// - sample serial input on falling clock edge
// - advance serial output on rising clock edge
// - chip select rise writes addressed register
// - chip select fall loads output status
// - idle select ignores clock, output released
// - direct inputs, wake or reset wake device
// - direct input n drives power output n while duty is disabled
// - fault flag pulled low on any fault
// - reset clears registers and enters sleep
// - reset rising edge starts the watchdog
// - sense selects output current or temperature
// - sense output can be set high impedance
// - clock fail check only enabled, external
// - duty 100 percent full on, 0 full off
// - words travel most significant bit first
// - five bit address selects written register
module lss_serial_port
	import lss_pkg::*;
#(
	parameter int WDOG_CYC = WDOG_CYCLES,
	parameter int CLKFAIL_CYC = CLKFAIL_CYCLES
) (
	// system clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// serial link, own clock domain
	input wire logic link_sclk,
	input wire logic cs_n,
	input wire logic si,
	output logic so_o,
	output logic so_oe,
	// device pins
	input wire logic rst_pin_n,
	input wire logic wake_in,
	input wire logic [NUM_OUT-1:0] direct_output_inputs,
	input wire logic [NUM_OUT-1:0] fault_det,
	output logic [NUM_OUT-1:0] power_outputs,
	output logic fault_flag_n_o,
	output logic fault_flag_n_oe,
	// sense output control
	output logic [1:0] load_sense_out_ch,
	output logic [1:0] load_sense_out_mode,
	// status
	output logic awake,
	output logic watchdog_expired,
	output logic clock_fail
);
	// ------------------------------------------------------------
	// link domain: shift registers on the serial clock
	// ------------------------------------------------------------
	logic [FRAME_BITS-1:0] rx_sh_r;
	logic [4:0] rx_cnt_r;
	logic [4:0] cnt_at_rise_r;
	logic [FRAME_BITS-1:0] tx_sh_r;
	logic [FRAME_BITS-1:0] status_word;
	logic [FRAME_BITS-1:0] status_sync_r;
	logic so_first_r;
	// bit count, cleared while deselected since the clock idles then
	always_ff @(negedge link_sclk or posedge cs_n) begin
		if (cs_n) begin
			rx_cnt_r <= 5'h00;
		end else if (rx_cnt_r != 5'(FRAME_BITS)) begin
			rx_cnt_r <= rx_cnt_r + 5'h01;
		end
	end
	// word and final count have no select clear, so they survive the
	// select rise; a select pulse with no clock at all is not caught
	always_ff @(negedge link_sclk) begin
		if (!cs_n) begin
			rx_sh_r <= {rx_sh_r[FRAME_BITS-2:0], si};
			cnt_at_rise_r <= rx_cnt_r + 5'h01;
		end
	end
	// transmit: bit 15 of the snapshot shows straight after select
	// falls; the first rising edge loads the rest, later ones shift
	always_ff @(posedge link_sclk or posedge cs_n) begin
		if (cs_n) begin
			tx_sh_r <= '0;
			so_first_r <= 1'b1;
		end else begin
			tx_sh_r <= so_first_r ? status_sync_r << 1
				: tx_sh_r << 1;
			so_first_r <= 1'b0;
		end
	end
	assign so_o = so_first_r ? status_sync_r[FRAME_BITS-1]
		: tx_sh_r[FRAME_BITS-1];
	// ------------------------------------------------------------
	// crossing: frame end event and word to sys domain
	// ------------------------------------------------------------
	logic [2:0] cs_sync_r;
	logic cs_lvl_r;
	logic cs_rise;
	logic [FRAME_BITS-1:0] rx_hold_r;
	logic wr_strobe_r;
	// select level changes once stages two and three agree
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			cs_sync_r <= 3'h7;
			cs_lvl_r <= 1'b1;
		end else begin
			cs_sync_r <= {cs_sync_r[1:0], cs_n};
			if (cs_sync_r[1] == cs_sync_r[2]) cs_lvl_r <= cs_sync_r[2];
		end
	end
	// word and count are still once select is high and the clock idle,
	// so sampling them at the synchronised select rise is safe
	assign cs_rise = cs_sync_r[1] && cs_sync_r[2] && !cs_lvl_r;
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			rx_hold_r <= '0;
			wr_strobe_r <= 1'b0;
		end else begin
			// only complete sixteen bit frames write
			wr_strobe_r <= cs_rise && cnt_at_rise_r == 5'(FRAME_BITS);
			if (cs_rise) begin
				rx_hold_r <= rx_sh_r;
			end
		end
	end
	// ------------------------------------------------------------
	// register file and decode
	// ------------------------------------------------------------
	logic [ADDR_BITS-1:0] wr_addr;
	logic [DATA_BITS-1:0] wr_data;
	logic [ADDR_BITS-1:0] rd_addr_r;
	logic [DATA_BITS-1:0] rd_data;
	logic pin_rst;
	assign wr_addr = rx_hold_r[ADDR_MSB:ADDR_LSB];
	assign wr_data = rx_hold_r[DATA_BITS-1:0];
	lss_regmem #(.AW(ADDR_BITS), .DW(DATA_BITS)) u_mem (
		.clk(sys_clk),
		.nrst(nrst && !pin_rst),
		.wr_en(wr_strobe_r),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.rd_addr(rd_addr_r),
		.rd_data(rd_data)
	);
	// frequently used registers shadowed as flops for parallel use
	logic [DATA_BITS-1:0] out_ctrl_r;
	logic [DATA_BITS-1:0] sense_r;
	logic [DATA_BITS-1:0] dcfg_r;
	logic [7:0] duty_r [NUM_OUT];
	logic [NUM_OUT-1:0] fault_lat_r;
	logic fault_clr;
	logic wr_go;
	assign wr_go = wr_strobe_r && !pin_rst;
	assign fault_clr = wr_go && wr_addr == ADDR_FAULT_CLR;
	always_ff @(posedge sys_clk) begin
		if (!nrst || pin_rst) begin
			out_ctrl_r <= REG_RESET;
			sense_r <= REG_RESET;
			dcfg_r <= REG_RESET;
		end else if (wr_go) begin
			if (wr_addr == ADDR_OUT_CTRL) out_ctrl_r <= wr_data;
			if (wr_addr == ADDR_SENSE) sense_r <= wr_data;
			if (wr_addr == ADDR_DUTY_CFG) dcfg_r <= wr_data;
		end
	end
	// ------------------------------------------------------------
	// pin synchronisers: three flops, change when stages 2,3 agree
	// ------------------------------------------------------------
	logic [2:0] rst_s_r;
	logic [2:0] wake_s_r;
	logic [2:0] fd_s_r [NUM_OUT];
	logic [2:0] din_s_r [NUM_OUT];
	logic rst_lvl_r;
	logic wake_lvl_r;
	logic [NUM_OUT-1:0] din_lvl_r;
	logic [NUM_OUT-1:0] fd_lvl_r;
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			rst_s_r <= 3'h0;
			wake_s_r <= 3'h0;
			rst_lvl_r <= 1'b0;
			wake_lvl_r <= 1'b0;
		end else begin
			rst_s_r <= {rst_s_r[1:0], rst_pin_n};
			wake_s_r <= {wake_s_r[1:0], wake_in};
			if (rst_s_r[1] == rst_s_r[2]) rst_lvl_r <= rst_s_r[2];
			if (wake_s_r[1] == wake_s_r[2]) wake_lvl_r <= wake_s_r[2];
		end
	end
	genvar g;
	generate
		for (g = 0; g < NUM_OUT; g++) begin : g_ch
			always_ff @(posedge sys_clk) begin
				if (!nrst) begin
					din_s_r[g] <= 3'h0;
					fd_s_r[g] <= 3'h0;
					din_lvl_r[g] <= 1'b0;
					fd_lvl_r[g] <= 1'b0;
				end else begin
					din_s_r[g] <= {din_s_r[g][1:0], direct_output_inputs[g]};
					fd_s_r[g] <= {fd_s_r[g][1:0], fault_det[g]};
					if (din_s_r[g][1] == din_s_r[g][2])
						din_lvl_r[g] <= din_s_r[g][2];
					if (fd_s_r[g][1] == fd_s_r[g][2])
						fd_lvl_r[g] <= fd_s_r[g][2];
				end
			end
			always_ff @(posedge sys_clk) begin
				if (!nrst || pin_rst) begin
					duty_r[g] <= 8'h00;
				end else if (wr_go && wr_addr == ADDR_DUTY0 + 5'(g)) begin
					duty_r[g] <= wr_data[7:0];
				end
			end
			// set wins over the clear
			always_ff @(posedge sys_clk) begin
				if (!nrst || pin_rst) begin
					fault_lat_r[g] <= 1'b0;
				end else if (fd_lvl_r[g]) begin
					fault_lat_r[g] <= 1'b1;
				end else if (fault_clr && wr_data[g]) begin
					fault_lat_r[g] <= 1'b0;
				end
			end
		end
	endgenerate
	assign pin_rst = !rst_lvl_r;
	// ------------------------------------------------------------
	// wake, mode and watchdog
	// ------------------------------------------------------------
	lss_mode_t mode_r;
	lss_mode_t mode_nxt;
	logic wake_any;
	logic any_fault;
	assign wake_any = rst_lvl_r || wake_lvl_r || |din_lvl_r;
	assign any_fault = |fault_lat_r;
	always_comb begin
		case (mode_r)
			LSS_SLEEP: mode_nxt = wake_any ? LSS_NORMAL : LSS_SLEEP;
			LSS_NORMAL: mode_nxt = !wake_any ? LSS_SLEEP
				: any_fault ? LSS_FAULT : LSS_NORMAL;
			LSS_FAULT: mode_nxt = !wake_any ? LSS_SLEEP
				: any_fault ? LSS_FAULT : LSS_NORMAL;
			default: mode_nxt = LSS_SLEEP;
		endcase
	end
	always_ff @(posedge sys_clk) begin
		if (!nrst || pin_rst) begin
			mode_r <= LSS_SLEEP;
		end else begin
			mode_r <= mode_nxt;
		end
	end
	logic rst_lvl_d_r;
	logic [31:0] wdog_r;
	logic wdog_run_r;
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			rst_lvl_d_r <= 1'b0;
			wdog_run_r <= 1'b0;
			wdog_r <= 32'h0;
		end else begin
			rst_lvl_d_r <= rst_lvl_r;
			if (rst_lvl_r && !rst_lvl_d_r) begin
				wdog_run_r <= 1'b1;
				wdog_r <= 32'h0;
			end else if (pin_rst) begin
				wdog_run_r <= 1'b0;
			end else if (wr_go) begin
				wdog_r <= 32'h0; // any valid frame services it
			end else if (wdog_run_r && wdog_r != 32'(WDOG_CYC)) begin
				wdog_r <= wdog_r + 32'h1;
			end
		end
	end
	// ------------------------------------------------------------
	// duty module and external clock failure detector
	// ------------------------------------------------------------
	logic duty_en;
	logic ext_src;
	logic det_on;
	logic ext_clk_d_r;
	logic [7:0] pwm_cnt_r;
	logic [31:0] cf_cnt_r;
	logic ext_tick;
	assign duty_en = dcfg_r[DCFG_EN_BIT];
	assign ext_src = !dcfg_r[DCFG_SRC_BIT];
	assign det_on = duty_en && ext_src;
	// external duty clock on input 0; internal source ticks each cycle
	assign ext_tick = ext_src ? (din_lvl_r[0] && !ext_clk_d_r)
		: 1'b1;
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			ext_clk_d_r <= 1'b0;
			pwm_cnt_r <= 8'h00;
			cf_cnt_r <= 32'h0;
		end else begin
			ext_clk_d_r <= din_lvl_r[0];
			if (ext_tick) pwm_cnt_r <= pwm_cnt_r + 8'h01;
			if (!det_on || ext_tick) cf_cnt_r <= 32'h0;
			else if (cf_cnt_r != 32'(CLKFAIL_CYC)) cf_cnt_r <= cf_cnt_r + 32'h1;
		end
	end
	logic [NUM_OUT-1:0] out_nxt;
	generate
		for (g = 0; g < NUM_OUT; g++) begin : g_out
			logic pwm_on;
			// full scale means always on, zero means always off
			assign pwm_on = duty_r[g] == DUTY_FULL
				|| pwm_cnt_r < duty_r[g];
			assign out_nxt[g] = mode_r == LSS_SLEEP ? 1'b0
				: fault_lat_r[g] ? 1'b0
				: duty_en ? (out_ctrl_r[g] && pwm_on)
				: (out_ctrl_r[g] || din_lvl_r[g]);
		end
	endgenerate
	// ------------------------------------------------------------
	// status word and outputs
	// ------------------------------------------------------------
	assign status_word = {1'b0, any_fault, mode_r, wdog_r == 32'(WDOG_CYC),
		cf_cnt_r == 32'(CLKFAIL_CYC), 1'b0, fault_lat_r, out_nxt};
	// snapshot taken at the synchronised select fall; it settles well
	// before the first rising clock edge given the lead time
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			status_sync_r <= '0;
			rd_addr_r <= '0;
		end else begin
			rd_addr_r <= wr_addr;
			if (cs_lvl_r) status_sync_r <= status_word;
		end
	end
	assign so_oe = !cs_n;
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			power_outputs <= '0;
			fault_flag_n_o <= 1'b0;
			fault_flag_n_oe <= 1'b0;
			load_sense_out_ch <= 2'h0;
			load_sense_out_mode <= LSS_SNS_HIZ;
			awake <= 1'b0;
			watchdog_expired <= 1'b0;
			clock_fail <= 1'b0;
		end else begin
			power_outputs <= out_nxt;
			fault_flag_n_oe <= any_fault;
			load_sense_out_ch <= sense_r[SNS_SEL_LSB+1:SNS_SEL_LSB];
			load_sense_out_mode <= sense_r[SNS_HIZ_BIT] ? LSS_SNS_HIZ
				: sense_r[SNS_TEMP_BIT] ? LSS_SNS_TEMP : LSS_SNS_CUR;
			awake <= mode_r != LSS_SLEEP;
			watchdog_expired <= wdog_r == 32'(WDOG_CYC);
			clock_fail <= cf_cnt_r == 32'(CLKFAIL_CYC);
		end
	end
	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_fault_flag: assert property (@(posedge sys_clk) disable iff (!nrst)
		any_fault |=> fault_flag_n_oe) else $error("fault flag late");
	a_sleep_off: assert property (@(posedge sys_clk) disable iff (!nrst)
		mode_r == LSS_SLEEP |=> power_outputs == '0)
		else $error("output on in sleep");
	a_pin_reset: assert property (@(posedge sys_clk) disable iff (!nrst)
		pin_rst |=> mode_r == LSS_SLEEP && dcfg_r == REG_RESET)
		else $error("reset did not clear");
	a_wake_src: assert property (@(posedge sys_clk) disable iff (!nrst)
		mode_r == LSS_SLEEP && wake_any && !pin_rst |=> mode_r == LSS_NORMAL)
		else $error("no wake");
	a_wdog_start: assert property (@(posedge sys_clk) disable iff (!nrst)
		rst_lvl_r && !rst_lvl_d_r |=> wdog_run_r && wdog_r == 32'h0)
		else $error("watchdog not started");
	a_clkfail_gate: assert property (@(posedge sys_clk) disable iff (!nrst)
		!det_on |=> cf_cnt_r == 32'h0) else $error("detector ran");
	a_duty_full: assert property (@(posedge sys_clk) disable iff (!nrst)
		mode_r == LSS_NORMAL && duty_en && out_ctrl_r[0] && !fault_lat_r[0]
		&& duty_r[0] == DUTY_FULL |=> power_outputs[0])
		else $error("full duty not on");
	a_sense_hiz: assert property (@(posedge sys_clk) disable iff (!nrst)
		sense_r[SNS_HIZ_BIT] |=> load_sense_out_mode == LSS_SNS_HIZ)
		else $error("sense not released");
	a_direct_in: assert property (@(posedge sys_clk) disable iff (!nrst)
		mode_r == LSS_NORMAL && !duty_en && din_lvl_r[1] && !fault_lat_r[1]
		|=> power_outputs[1]) else $error("direct input ignored");
	c_write: cover property (@(posedge sys_clk) wr_go);
	c_fault: cover property (@(posedge sys_clk) mode_r == LSS_FAULT);
	c_clkfail: cover property (@(posedge sys_clk) clock_fail);
endmodule

//--- dv/lss_host_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// host master model, drives the serial link of the port
// ------------------------------------------------------------
module lss_host_model (
	// serial link driven by the host
	output logic link_sclk,
	output logic cs_n,
	output logic si,
	// data back from the device
	input wire logic so_o,
	input wire logic so_oe
);
	// idle: select high, clock low, data at its pull-down level
	initial begin
		link_sclk = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
	end
	// one frame, 160 ns clock period so well under the rate limit
	// nbits other than 16 gives a frame the port must refuse
	task automatic xfer(input logic [15:0] w, input int nbits,
		output logic [15:0] rx);
		logic [15:0] ws;
		ws = w;
		rx = 16'h0000;
		#1ns; // keeps the link edges off the system clock edges
		si = ws[15];
		cs_n = 1'b0;
		#420ns;
		for (int i = 0; i < nbits; i++) begin
			#40ns;
			// an undriven line reads as unknown so it can never match
			if (i < 16)
				rx = {rx[14:0], so_oe ? so_o : 1'bx};
			// data moves on the rising edge, the port samples it on the fall
			#40ns link_sclk = 1'b1;
			si = ws[15];
			ws = ws << 1;
			#80ns link_sclk = 1'b0;
		end
		#80ns cs_n = 1'b1;
		si = 1'b0;
		#1000ns;
	endtask
endmodule

//--- dv/tb_lss_serial_port.sv
`timescale 1ns/1ps
module tb_lss_serial_port
	import lss_pkg::*;
;
	// ------------------------------------------------------------
	// signals and design under test
	// ------------------------------------------------------------
	localparam int WDOG = 4000;
	logic sys_clk = 1'b0;
	logic nrst, link_sclk, cs_n, si, so_o, so_oe, rst_pin_n, wake_in;
	logic [3:0] din, fault_det, pout;
	logic ff_o, ff_oe, awake, wd_exp, clock_fail;
	logic [1:0] sns_ch, sns_mode;
	logic [15:0] rx;
	int mismatches = 0;
	int checks_done = 0;
	int n;
	typedef struct {
		logic [4:0] a;
		logic [9:0] d;
		logic [3:0] din;
		logic [3:0] pout;
		logic [1:0] mode;
		logic [1:0] ch;
	} lss_row_t;
	// writes with the outputs and sense selection they should give
	lss_row_t rows [12] = '{
		'{5'h02, 10'h002, 4'h0, 4'h0, 2'h1, 2'h2},
		'{5'h02, 10'h004, 4'h0, 4'h0, 2'h2, 2'h0},
		'{5'h02, 10'h008, 4'h0, 4'h0, 2'h0, 2'h0},
		'{5'h1F, 10'h3FF, 4'h0, 4'h0, 2'h0, 2'h0},
		'{5'h01, 10'h005, 4'h0, 4'h5, 2'h0, 2'h0},
		'{5'h01, 10'h000, 4'hA, 4'hA, 2'h0, 2'h0},
		'{5'h04, 10'h0FF, 4'h0, 4'h0, 2'h0, 2'h0},
		'{5'h01, 10'h001, 4'h0, 4'h1, 2'h0, 2'h0},
		'{5'h08, 10'h003, 4'h0, 4'h1, 2'h0, 2'h0},
		'{5'h04, 10'h000, 4'h0, 4'h0, 2'h0, 2'h0},
		'{5'h08, 10'h000, 4'h0, 4'h1, 2'h0, 2'h0},
		'{5'h01, 10'h000, 4'h0, 4'h0, 2'h0, 2'h0}
	};
	// system clock, 4 ns period
	always #2ns sys_clk = ~sys_clk;
	lss_host_model host (.link_sclk(link_sclk), .cs_n(cs_n), .si(si),
		.so_o(so_o), .so_oe(so_oe));
	// short watchdog and clock-fail counts keep the run brief
	lss_serial_port #(.WDOG_CYC(WDOG), .CLKFAIL_CYC(64)) DUT (
		.sys_clk(sys_clk), .nrst(nrst), .link_sclk(link_sclk),
		.cs_n(cs_n), .si(si), .so_o(so_o), .so_oe(so_oe),
		.rst_pin_n(rst_pin_n), .wake_in(wake_in),
		.direct_output_inputs(din), .fault_det(fault_det),
		.power_outputs(pout), .fault_flag_n_o(ff_o),
		.fault_flag_n_oe(ff_oe), .load_sense_out_ch(sns_ch),
		.load_sense_out_mode(sns_mode), .awake(awake),
		.watchdog_expired(wd_exp), .clock_fail(clock_fail));
	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic check(input string name, input logic [15:0] seen,
		input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// a write lands a few system cycles after select rises
	task automatic wr(input logic [4:0] a, input logic [9:0] d,
		input int nb);
		host.xfer({1'b0, a, d}, nb, rx);
		repeat (12) @(negedge sys_clk);
	endtask
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		nrst = 1'b0;
		rst_pin_n = 1'b0;
		wake_in = 1'b0;
		din = 4'h0;
		fault_det = 4'h0;
		repeat (6) @(negedge sys_clk);
		nrst = 1'b1;
		repeat (10) @(negedge sys_clk);
		check("awake_sleep", {15'h0, awake}, 16'h0);
		check("so_oe_idle", {15'h0, so_oe}, 16'h0);
		rst_pin_n = 1'b1;
		repeat (1250) @(negedge sys_clk);
		check("awake_wake", {15'h0, awake}, 16'h1);
		// table of ordinary writes
		for (int i = 0; i < 12; i++) begin
			din = rows[i].din;
			repeat (10) @(negedge sys_clk);
			wr(rows[i].a, rows[i].d, 16);
			check("pout", {12'h0, pout}, {12'h0, rows[i].pout});
			check("sns_mode", {14'h0, sns_mode}, {14'h0, rows[i].mode});
			check("sns_ch", {14'h0, sns_ch}, {14'h0, rows[i].ch});
			if (i > 0 && rows[i-1].din == 4'h0 && rows[i].din == 4'h0) begin
				check("st_outs", {12'h0, rx[3:0]}, {12'h0, rows[i-1].pout});
				check("st_mode", {13'h0, rx[13:11]}, {13'h0, LSS_NORMAL});
			end
		end
		// frames of the wrong length leave the outputs alone
		wr(ADDR_OUT_CTRL, 10'h00F, 15);
		check("short_frame", {12'h0, pout}, 16'h0);
		wr(ADDR_OUT_CTRL, 10'h00F, 17);
		check("long_frame", {12'h0, pout}, 16'h0);
		check("so_oe_after", {15'h0, so_oe}, 16'h0);
		// brief fault stays latched until cleared by mask
		fault_det = 4'h2;
		repeat (20) @(negedge sys_clk);
		fault_det = 4'h0;
		repeat (10) @(negedge sys_clk);
		check("fault_oe", {15'h0, ff_oe}, 16'h1);
		check("fault_o", {15'h0, ff_o}, 16'h0);
		wr(5'h1F, 10'h000, 16);
		check("st_faults", {12'h0, rx[7:4]}, 16'h2);
		check("st_fault", {15'h0, rx[14]}, 16'h1);
		wr(ADDR_FAULT_CLR, 10'h002, 16);
		check("fault_clr", {15'h0, ff_oe}, 16'h0);
		// clock-fail detector only with external duty clock chosen
		wr(ADDR_DUTY_CFG, 10'h003, 16);
		repeat (200) @(negedge sys_clk);
		check("cf_internal", {15'h0, clock_fail}, 16'h0);
		wr(ADDR_DUTY_CFG, 10'h001, 16);
		n = 0;
		while (clock_fail !== 1'b1 && n < 400) begin
			@(negedge sys_clk);
			n++;
		end
		check("cf_external", {15'h0, clock_fail}, 16'h1);
		if (n >= 400)
			tally_and_finish();
		// a running external clock on input 0 keeps the detector quiet
		for (int k = 0; k < 12; k++) begin
			din[0] = ~din[0];
			repeat (16) @(negedge sys_clk);
		end
		check("cf_ext_clock", {15'h0, clock_fail}, 16'h0);
		din = 4'h0;
		// reset pin clears, sleeps, and its release starts the watchdog
		wr(ADDR_DUTY_CFG, 10'h000, 16);
		wr(ADDR_OUT_CTRL, 10'h00F, 16);
		rst_pin_n = 1'b0;
		repeat (2600) @(negedge sys_clk);
		check("rst_awake", {15'h0, awake}, 16'h0);
		check("rst_pout", {12'h0, pout}, 16'h0);
		rst_pin_n = 1'b1;
		repeat (20) @(negedge sys_clk);
		check("rst_cleared", {12'h0, pout}, 16'h0);
		repeat (WDOG - 120) @(negedge sys_clk);
		check("wdog_early", {15'h0, wd_exp}, 16'h0);
		n = 0;
		while (wd_exp !== 1'b1 && n < 300) begin
			@(negedge sys_clk);
			n++;
		end
		check("wdog_late", {15'h0, wd_exp}, 16'h1);
		tally_and_finish();
	end
endmodule
